// ### addr_map_pkg.sv
package addr_map_pkg;
    localparam int PROG_WORDS_SMALL = 2048;
    localparam int PROG_WORDS_LARGE = 4096;
    localparam int PC_W_SMALL = 11;
    localparam int PC_W_LARGE = 12;
    localparam int PROG_DATA_W = 16;
    localparam int DADDR_W = 16;
    localparam logic [15:0] WREG_BASE = 16'h0000;
    localparam logic [15:0] WREG_LAST = 16'h001F;
    localparam logic [15:0] IO_BASE = 16'h0020;
    localparam logic [15:0] IO_LAST = 16'h005F;
    localparam logic [15:0] EXT_BASE = 16'h0060;
    localparam logic [15:0] EXT_LAST = 16'h00FF;
    localparam logic [15:0] SRAM_BASE = 16'h0100;
    localparam logic [15:0] SRAM_LAST_SMALL = 16'h01FF;
    localparam logic [15:0] SRAM_LAST_LARGE = 16'h02FF;
    localparam logic [5:0] IO_SHORT_LAST = 6'h3F;
    localparam logic [5:0] IO_BIT_LAST = 6'h1F;
    localparam logic [5:0] DISP_MAX = 6'h3F;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    localparam logic [5:0] SCRATCH0_IO = 6'h15;
    localparam logic [5:0] SCRATCH1_IO = 6'h16;
    localparam logic [5:0] SCRATCH2_IO = 6'h17;
    localparam int SRAM_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_DIRECT = 3'b001,
        OP_POINTER = 3'b010,
        OP_DISPLACED = 3'b011,
        OP_PRE_DEC = 3'b100,
        OP_POST_INC = 3'b101,
        OP_IO = 3'b110,
        OP_IO_BIT = 3'b111
    } addr_mode_t;

    typedef enum logic [1:0] {
        PTR_X = 2'b00,
        PTR_Y = 2'b01,
        PTR_Z = 2'b10
    } ptr_sel_t;

    typedef enum logic [1:0] {
        BIT_SET = 2'b00,
        BIT_CLEAR = 2'b01,
        BIT_TEST = 2'b10
    } bit_op_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_SRAM2 = 2'b01,
        ACC_DONE = 2'b10
    } acc_state_t;
endpackage : addr_map_pkg

// ### prog_mem_port.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem_port #(
    parameter bit LARGE = 1'b0,
    parameter int PC_W = 11
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fetch_req,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic const_req,
    input wire logic [PC_W:0] const_byte_addr,
    input wire logic [15:0] prog_rdata,
    output logic [PC_W-1:0] prog_addr,
    output logic [15:0] instr_word,
    output logic [7:0] const_byte,
    output logic prog_valid
);
    import addr_map_pkg::*;

    // Constant byte loads take priority over fetch for the memory port
    wire logic const_sel = const_req;
    wire logic [PC_W-1:0] const_word = const_byte_addr[PC_W:1];
    assign prog_addr = const_sel ? const_word : fetch_addr;
    wire logic fetch_sel = fetch_req && !const_sel;
    wire logic [7:0] byte_pick = const_byte_addr[0] ? prog_rdata[15:8] : prog_rdata[7:0];

    // Word captured at the taking edge, while its address still stands
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_word <= 16'h0000;
            const_byte <= 8'h00;
            prog_valid <= 1'b0;
        end else begin
            prog_valid <= const_sel | fetch_sel;
            if (fetch_sel) begin
                instr_word <= prog_rdata;
            end
            if (const_sel) begin
                const_byte <= byte_pick;
            end
        end
    end
endmodule : prog_mem_port
`default_nettype wire

// ### data_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module data_space_decoder #(
    parameter bit LARGE = 1'b0,
    parameter int PC_W = 11
) (
    input wire logic clk,
    input wire logic rst_b,
    // Request from the load/store unit
    input wire logic req,
    input wire logic wr,
    input wire addr_map_pkg::addr_mode_t mode,
    input wire addr_map_pkg::ptr_sel_t ptr_sel,
    input wire logic [15:0] direct_addr,
    input wire logic [5:0] disp,
    input wire logic [5:0] io_addr,
    input wire addr_map_pkg::bit_op_t bit_op,
    input wire logic [2:0] bit_idx,
    input wire logic [7:0] wdata,
    output logic busy,
    output logic done,
    output logic [7:0] rdata,
    output logic bit_result,
    output logic refused,
    output logic [15:0] eff_addr,
    // Working register file port
    output logic [4:0] wreg_addr,
    output logic wreg_we,
    output logic [7:0] wreg_wdata,
    input wire logic [7:0] wreg_rdata,
    // Pointer pairs as held in registers 26 through 31
    input wire logic [15:0] ptr_x,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    output logic ptr_we,
    output logic [4:0] ptr_lo_idx,
    output logic [15:0] ptr_wdata,
    // Peripheral I/O port (standard and extended)
    output logic [7:0] io_data_addr,
    output logic io_re,
    output logic io_we,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // SRAM port
    output logic [9:0] sram_addr,
    output logic sram_en,
    output logic sram_we,
    output logic [7:0] sram_wdata,
    input wire logic [7:0] sram_rdata,
    // Program memory
    input wire logic fetch_req,
    input wire logic [PC_W-1:0] fetch_addr,
    input wire logic const_req,
    input wire logic [PC_W:0] const_byte_addr,
    input wire logic [15:0] prog_rdata,
    output logic [PC_W-1:0] prog_addr,
    output logic [15:0] instr_word,
    output logic [7:0] const_byte,
    output logic prog_valid
);
    import addr_map_pkg::*;

    // =========================================================
    // Variant limits
    // =========================================================
    localparam logic [15:0] SRAM_LAST = LARGE ? SRAM_LAST_LARGE : SRAM_LAST_SMALL;

    // =========================================================
    // Effective address
    // =========================================================
    wire logic [15:0] ptr_val = (ptr_sel == PTR_X) ? ptr_x :
                                (ptr_sel == PTR_Y) ? ptr_y : ptr_z;
    wire logic disp_ptr_ok = (ptr_sel == PTR_Y) || (ptr_sel == PTR_Z);
    wire logic [15:0] disp_ext = {10'h000, disp & DISP_MAX};
    wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
    wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
    wire logic [15:0] io_long = {10'h000, io_addr} + IO_BASE;
    wire logic is_io = (mode == OP_IO) || (mode == OP_IO_BIT);
    wire logic bit_ok = (io_addr <= IO_BIT_LAST);
    wire logic short_ok = (io_addr <= IO_SHORT_LAST);
    logic [15:0] ea;

    always_comb begin
        case (mode)
            OP_DIRECT: ea = direct_addr;
            OP_POINTER: ea = ptr_val;
            OP_DISPLACED: ea = ptr_val + disp_ext;
            OP_PRE_DEC: ea = ptr_dec;
            OP_POST_INC: ea = ptr_val;
            OP_IO: ea = io_long;
            OP_IO_BIT: ea = io_long;
            default: ea = 16'h0000;
        endcase
    end

    // =========================================================
    // Request checks
    // =========================================================
    wire logic bad_none = (mode == OP_NONE);
    wire logic bad_disp = (mode == OP_DISPLACED) && !disp_ptr_ok;
    wire logic bad_bit = (mode == OP_IO_BIT) && !bit_ok;
    wire logic bad_short = is_io && !short_ok;
    wire logic bad_req = bad_none || bad_disp || bad_bit || bad_short;

    // =========================================================
    // Region decode, same for every mode
    // =========================================================
    wire logic hit_wreg = (ea <= WREG_LAST);
    wire logic hit_io = (ea >= IO_BASE) && (ea <= IO_LAST);
    wire logic hit_ext = (ea >= EXT_BASE) && (ea <= EXT_LAST);
    wire logic hit_sram = (ea >= SRAM_BASE) && (ea <= SRAM_LAST);
    wire logic hit_none = !(hit_wreg || hit_io || hit_ext || hit_sram);
    wire logic [15:0] sram_off = ea - SRAM_BASE;

    // Scratch registers addressed by their data-space location
    wire logic [15:0] scr0_a = {10'h000, SCRATCH0_IO} + IO_BASE;
    wire logic [15:0] scr1_a = {10'h000, SCRATCH1_IO} + IO_BASE;
    wire logic [15:0] scr2_a = {10'h000, SCRATCH2_IO} + IO_BASE;
    wire logic [1:0] scr_idx = (ea == scr0_a) ? 2'd0 : (ea == scr1_a) ? 2'd1 : 2'd2;
    wire logic hit_scr = (ea == scr0_a) || (ea == scr1_a) || (ea == scr2_a);

    // =========================================================
    // Access sequencing
    // =========================================================
    acc_state_t state_r;
    acc_state_t state_nxt;
    logic [15:0] ea_r;
    logic wr_r;
    logic [7:0] wdata_r;
    logic [7:0] scratch_r [0:2];
    wire logic accept = req && (state_r == ACC_IDLE) && !bad_req;
    wire logic is_bit = (mode == OP_IO_BIT);

    always_comb begin
        case (state_r)
            ACC_IDLE: state_nxt = (accept && hit_sram) ? ACC_SRAM2 : ACC_IDLE;
            ACC_SRAM2: state_nxt = ACC_IDLE;
            default: state_nxt = ACC_IDLE;
        endcase
    end

    // =========================================================
    // Read data for the single-cycle regions
    // =========================================================
    logic [7:0] fast_rd;
    always_comb begin
        if (hit_wreg) begin
            fast_rd = wreg_rdata;
        end else if (hit_scr) begin
            fast_rd = scratch_r[scr_idx];
        end else if (hit_io || hit_ext) begin
            fast_rd = io_rdata;
        end else begin
            fast_rd = 8'h00;
        end
    end

    // =========================================================
    // Bit set and clear read-modify-write the addressed byte; bit test only reads it
    // =========================================================
    wire logic [7:0] bit_mask = 8'h01 << bit_idx;
    wire logic [7:0] bit_new = (bit_op == BIT_SET) ? (fast_rd | bit_mask) :
                               (fast_rd & ~bit_mask);
    wire logic bit_wr = is_bit && (bit_op != BIT_TEST);
    wire logic eff_wr = bit_wr || (!is_bit && wr);
    wire logic [7:0] eff_wdata = is_bit ? bit_new : wdata;
    wire logic fast_wr = accept && eff_wr && !hit_sram && !hit_none;

    // =========================================================
    // Register file, peripheral and SRAM ports
    // =========================================================
    // Bit operations read the byte they rewrite
    wire logic io_rd_need = !eff_wr || is_bit;
    wire logic hit_periph = (hit_io || hit_ext) && !hit_scr;
    assign wreg_addr = ea[4:0];
    assign wreg_we = fast_wr && hit_wreg;
    assign wreg_wdata = eff_wdata;
    assign io_data_addr = ea[7:0];
    assign io_re = accept && io_rd_need && hit_periph;
    assign io_we = fast_wr && hit_periph;
    assign io_wdata = eff_wdata;
    assign sram_addr = (state_r == ACC_SRAM2) ? ea_r[9:0] - SRAM_BASE[9:0] : sram_off[9:0];
    assign sram_en = (accept && hit_sram) || (state_r == ACC_SRAM2);
    assign sram_we = (state_r == ACC_SRAM2) && wr_r;
    assign sram_wdata = wdata_r;
    assign busy = (state_r == ACC_SRAM2);

    // =========================================================
    // Pointer write-back into registers 26..31
    // =========================================================
    wire logic ptr_upd = accept && ((mode == OP_PRE_DEC) || (mode == OP_POST_INC));
    assign ptr_we = ptr_upd;
    assign ptr_lo_idx = (ptr_sel == PTR_X) ? PTR_X_LO :
                        (ptr_sel == PTR_Y) ? PTR_Y_LO : PTR_Z_LO;
    assign ptr_wdata = (mode == OP_PRE_DEC) ? ptr_dec : ptr_inc;

    // =========================================================
    // Sequencer and request capture
    // =========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ACC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ea_r <= 16'h0000;
            wr_r <= 1'b0;
            wdata_r <= 8'h00;
        end else if (accept) begin
            ea_r <= ea;
            wr_r <= wr;
            wdata_r <= wdata;
        end
    end

    // =========================================================
    // Scratch registers, storage only
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_scratch
            wire logic scr_we = fast_wr && hit_scr && (scr_idx == 2'(g));
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    scratch_r[g] <= 8'h00;
                end else if (scr_we) begin
                    scratch_r[g] <= eff_wdata;
                end
            end
        end
    endgenerate

    // =========================================================
    // Answer registers
    // =========================================================
    wire logic fast_done = accept && !hit_sram;
    wire logic sram_done = (state_r == ACC_SRAM2);
    wire logic refuse_nxt = req && (state_r == ACC_IDLE) && bad_req;
    wire logic done_nxt = fast_done || sram_done;
    wire logic [7:0] sram_rd = wr_r ? 8'h00 : sram_rdata;
    wire logic [7:0] rdata_nxt = fast_done ? fast_rd :
                                 sram_done ? sram_rd : rdata;
    wire logic bit_nxt = fast_done ? fast_rd[bit_idx] :
                         sram_done ? 1'b0 : bit_result;
    wire logic [15:0] eff_addr_nxt = accept ? ea : eff_addr;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
            refused <= 1'b0;
        end else begin
            done <= done_nxt;
            refused <= refuse_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
            bit_result <= 1'b0;
            eff_addr <= 16'h0000;
        end else begin
            rdata <= rdata_nxt;
            bit_result <= bit_nxt;
            eff_addr <= eff_addr_nxt;
        end
    end

    // =========================================================
    // Program memory
    // =========================================================
    prog_mem_port #(
        .LARGE(LARGE),
        .PC_W(PC_W)
    ) u_prog (
        .clk(clk),
        .rst_b(rst_b),
        .fetch_req(fetch_req),
        .fetch_addr(fetch_addr),
        .const_req(const_req),
        .const_byte_addr(const_byte_addr),
        .prog_rdata(prog_rdata),
        .prog_addr(prog_addr),
        .instr_word(instr_word),
        .const_byte(const_byte),
        .prog_valid(prog_valid)
    );
endmodule : data_space_decoder
`default_nettype wire

// ### dsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic busy,
    input wire logic done,
    input wire logic refused,
    input wire addr_map_pkg::addr_mode_t mode,
    input wire addr_map_pkg::ptr_sel_t ptr_sel,
    input wire logic [15:0] direct_addr,
    input wire logic [5:0] disp,
    input wire logic [5:0] io_addr,
    input wire logic [15:0] eff_addr,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    input wire logic ptr_we,
    input wire logic [4:0] ptr_lo_idx,
    input wire logic [15:0] ptr_wdata,
    input wire logic [7:0] io_data_addr,
    input wire logic io_we,
    input wire logic const_req,
    input wire logic prog_valid
);
    import addr_map_pkg::*;
    // ====================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic go = req && !busy;
    property p_sram_two; busy |=> done && !busy; endproperty
    a_sram_two: assert property (p_sram_two) else $error("sram access length");
    property p_fast; go && mode == OP_DIRECT && direct_addr < SRAM_BASE |=> done; endproperty
    a_fast: assert property (p_fast) else $error("register access late");
    property p_io; go && mode == OP_IO |-> io_data_addr == {2'b00, io_addr} + 8'h20; endproperty
    a_io: assert property (p_io) else $error("short io mapping");
    property p_bit;
        go && mode == OP_IO_BIT && io_addr > IO_BIT_LAST |-> !io_we ##1 refused && !done;
    endproperty
    a_bit: assert property (p_bit) else $error("bit op range");
    property p_disp;
        go && mode == OP_DISPLACED && ptr_sel == PTR_Y |=>
            eff_addr == $past(ptr_y) + {10'h000, $past(disp)};
    endproperty
    a_disp: assert property (p_disp) else $error("displacement address");
    property p_predec;
        go && mode == OP_PRE_DEC && ptr_sel == PTR_Z |->
            ptr_we && ptr_lo_idx == PTR_Z_LO && ptr_wdata == ptr_z - 16'h0001;
    endproperty
    a_predec: assert property (p_predec) else $error("pre-decrement");
    property p_postinc;
        go && mode == OP_POST_INC && ptr_sel == PTR_Z |->
            ptr_wdata == ptr_z + 16'h0001 ##1 eff_addr == $past(ptr_z);
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment");
    property p_prog; const_req |=> prog_valid; endproperty
    a_prog: assert property (p_prog) else $error("constant load late");
endmodule : dsd_checker
bind data_space_decoder dsd_checker chk_i (.*);
`default_nettype wire

// ### mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clk,
    input wire logic [4:0] wreg_addr,
    input wire logic wreg_we,
    input wire logic [7:0] wreg_wdata,
    output logic [7:0] wreg_rdata,
    output logic [15:0] ptr_x,
    output logic [15:0] ptr_y,
    output logic [15:0] ptr_z,
    input wire logic ptr_we,
    input wire logic [4:0] ptr_lo_idx,
    input wire logic [15:0] ptr_wdata,
    input wire logic [7:0] io_data_addr,
    input wire logic io_re,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [9:0] sram_addr,
    input wire logic sram_en,
    input wire logic sram_we,
    input wire logic [7:0] sram_wdata,
    output logic [7:0] sram_rdata,
    input wire logic [10:0] prog_addr,
    output logic [15:0] prog_rdata
);
    // ====================
    // Register file, I/O, SRAM, program words
    logic [7:0] w [32];
    logic [7:0] io [256];
    logic [7:0] sr [1024];
    assign wreg_rdata = w[wreg_addr];
    assign ptr_x = {w[27], w[26]};
    assign ptr_y = {w[29], w[28]};
    assign ptr_z = {w[31], w[30]};
    // Unselected ports return garbage
    assign io_rdata = io_re ? io[io_data_addr] : ~io[io_data_addr];
    assign sram_rdata = sram_en ? sr[sram_addr] : ~sr[sram_addr];
    assign prog_rdata = {5'h15, prog_addr};
    always @(posedge clk) begin
        if (wreg_we) w[wreg_addr] <= wreg_wdata;
        if (ptr_we) begin
            w[ptr_lo_idx] <= ptr_wdata[7:0];
            w[ptr_lo_idx + 5'd1] <= ptr_wdata[15:8];
        end
        if (io_we) io[io_data_addr] <= io_wdata;
        if (sram_en && sram_we) sr[sram_addr] <= sram_wdata;
    end
endmodule : mem_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import addr_map_pkg::*;
    logic clk, busy, done, refused, bit_result, wreg_we, ptr_we, io_re, io_we;
    logic rst_b = 1'b0, req = 1'b0, wr = 1'b0, fetch_req = 1'b0, const_req = 1'b0;
    logic sram_en, sram_we, prog_valid, rf;
    addr_mode_t mode = OP_NONE;
    ptr_sel_t ptr_sel = PTR_X;
    bit_op_t bit_op = BIT_SET;
    logic [2:0] bit_idx = 3'h0;
    logic [4:0] wreg_addr, ptr_lo_idx;
    logic [5:0] disp = 6'h00, io_addr = 6'h00;
    logic [7:0] wdata = 8'h00, rdata, wreg_wdata, wreg_rdata, io_data_addr, io_wdata, io_rdata;
    logic [7:0] sram_wdata, sram_rdata, const_byte, got;
    logic [9:0] sram_addr;
    logic [10:0] fetch_addr = 11'h000, prog_addr;
    logic [11:0] const_byte_addr = 12'h000;
    logic [15:0] direct_addr = 16'h0000, eff_addr, ptr_x, ptr_y, ptr_z, ptr_wdata;
    logic [15:0] prog_rdata, instr_word;
    int errors = 0, checked = 0, cyc = 0, lat;
    data_space_decoder #(.LARGE(1'b0), .PC_W(11)) uut (.*);
    mem_model far (.*);
    // ====================
    // Clock, timeout, helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input addr_mode_t m, input logic w, input logic [15:0] a,
                       input logic [7:0] d, input logic [1:0] s);
        @(posedge clk);
        mode <= m;
        wr <= w;
        direct_addr <= a;
        io_addr <= a[5:0];
        disp <= a[5:0];
        wdata <= d;
        bit_idx <= d[2:0];
        ptr_sel <= ptr_sel_t'(s);
        bit_op <= bit_op_t'(s);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        lat = 0;
        #1;
        while (done !== 1'b1 && refused !== 1'b1 && lat < 4) begin
            @(posedge clk);
            #1;
            lat++;
        end
        got = rdata;
        rf = refused;
    endtask : acc
    // ====================
    // Scenarios
    task automatic t_regions;
        logic [15:0] a [6];
        a = '{16'h001F, 16'h0020, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
        for (int i = 0; i < 6; i++) begin
            acc(OP_DIRECT, 1'b1, a[i], 8'h40 + 8'(i), 2'd0);
            acc(OP_DIRECT, 1'b0, a[i], 8'h00, 2'd0);
            chk(got, i == 5 ? 8'h00 : 8'h40 + 8'(i));
            chk(16'(lat), a[i][8] ? 16'h1 : 16'h0);
        end
        acc(OP_DIRECT, 1'b0, 16'h0100, 8'h00, 2'd0);
        chk(got, 8'h43);
    endtask : t_regions
    task automatic t_io;
        acc(OP_IO, 1'b1, 16'h003F, 8'h5A, 2'd0);
        acc(OP_DIRECT, 1'b0, 16'h005F, 8'h00, 2'd0);
        chk(got, 8'h5A);
        acc(OP_DIRECT, 1'b1, 16'h0020, 8'hC3, 2'd0);
        acc(OP_IO, 1'b0, 16'h0000, 8'h00, 2'd0);
        chk(got, 8'hC3);
    endtask : t_io
    task automatic t_bits;
        acc(OP_DIRECT, 1'b1, 16'h0036, 8'h81, 2'd0);
        acc(OP_IO_BIT, 1'b0, 16'h0016, 8'h05, 2'd0);
        acc(OP_IO_BIT, 1'b0, 16'h0016, 8'h07, 2'd1);
        acc(OP_DIRECT, 1'b0, 16'h0036, 8'h00, 2'd0);
        chk(got, 8'h21);
        acc(OP_IO_BIT, 1'b0, 16'h0016, 8'h00, 2'd2);
        chk(bit_result, 1'b1);
        acc(OP_IO_BIT, 1'b0, 16'h0020, 8'h00, 2'd0);
        chk(rf, 1'b1);
        acc(OP_DIRECT, 1'b1, 16'h0021, 8'h00, 2'd0);
        acc(OP_IO_BIT, 1'b0, 16'h0001, 8'h03, 2'd0);
        acc(OP_DIRECT, 1'b0, 16'h0021, 8'h00, 2'd0);
        chk(got, 8'h08);
    endtask : t_bits
    task automatic t_ptr;
        acc(OP_DIRECT, 1'b1, 16'h001C, 8'h00, 2'd0);
        acc(OP_DIRECT, 1'b1, 16'h001D, 8'h01, 2'd0);
        acc(OP_DIRECT, 1'b1, 16'h013F, 8'h6E, 2'd0);
        acc(OP_DISPLACED, 1'b0, 16'h003F, 8'h00, 2'd1);
        chk(got, 8'h6E);
        chk(eff_addr, 16'h013F);
        acc(OP_DISPLACED, 1'b0, 16'h0001, 8'h00, 2'd0);
        chk(rf, 1'b1);
        acc(OP_DIRECT, 1'b1, 16'h001E, 8'h00, 2'd0);
        acc(OP_DIRECT, 1'b1, 16'h001F, 8'h01, 2'd0);
        acc(OP_PRE_DEC, 1'b1, 16'h0000, 8'h99, 2'd2);
        chk(eff_addr, 16'h00FF);
        acc(OP_DIRECT, 1'b0, 16'h001E, 8'h00, 2'd0);
        chk(got, 8'hFF);
        acc(OP_POST_INC, 1'b0, 16'h0000, 8'h00, 2'd2);
        chk(got, 8'h99);
        acc(OP_DIRECT, 1'b0, 16'h001F, 8'h00, 2'd0);
        chk(got, 8'h01);
        acc(OP_POINTER, 1'b0, 16'h0000, 8'h00, 2'd2);
        chk(got, 8'h43);
    endtask : t_ptr
    task automatic t_prog;
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= 11'h7FF;
        @(posedge clk);
        fetch_req <= 1'b0;
        #1;
        chk(instr_word, {5'h15, 11'h7FF});
        chk(prog_valid, 1'b1);
        @(posedge clk);
        const_req <= 1'b1;
        const_byte_addr <= 12'hFFF;
        fetch_addr <= 11'h000;
        @(posedge clk);
        const_req <= 1'b0;
        #1;
        chk(const_byte, 8'hAF);
        chk(prog_valid, 1'b1);
    endtask : t_prog
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_regions();
        t_io();
        t_bits();
        t_ptr();
        t_prog();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
